// *** rtl/supervisor_defines.vh ***
// Register map, field positions, reset values and timing for the supervisor
`ifndef SUPERVISOR_DEFINES_VH
`define SUPERVISOR_DEFINES_VH

// Register byte offsets
`define REG_TICK_DIV 8'h00
`define REG_RESET_DELAY_ONE 8'h04
`define REG_RESET_DELAY_TWO 8'h08
`define REG_WD_FAST 8'h0c
`define REG_WD_SLOW 8'h10
`define REG_STATUS 8'h14

// Timing: clock period and tick period in ns
`define CLK_PERIOD_NS 10
`define TICK_PERIOD_NS 1000
// Cycles per tick: TICK_PERIOD_NS over CLK_PERIOD_NS, sized for the register
`define TICK_DIV_RESET 16'h0064

// Reset values of programmed periods, in ticks of 1 us
`define RESET_DELAY_ONE_RESET 16'h5bcc
`define RESET_DELAY_TWO_RESET 16'h5bcc
`define WD_FAST_RESET 16'h04e2
`define WD_SLOW_RESET 16'h4e20

// Sequencing modes decoded from the strap
`define MODE_TIED_HIGH 2'h0
`define MODE_TIED_LOW 2'h1
`define MODE_OPEN 2'h2

// Status register field positions
`define ST_MODE_LSB 0
`define ST_RESET_ONE 2
`define ST_RESET_TWO 3
`define ST_WD_FAULT_N 4
`define ST_SWITCH_ONE 5
`define ST_SWITCH_TWO 6
`define ST_PULLDOWN_ONE 7
`define ST_PULLDOWN_TWO 8
`define ST_WD_ARMED 9
`define ST_SHUTDOWN 10

`endif

// *** rtl/input_sync.v ***
// Two-flop synchroniser bank for asynchronous comparator and pin inputs
`timescale 1ns/1ps
`default_nettype none

module input_sync #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Raw and synchronised levels
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] stage_one;

  // First stage feeds only the second stage
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage_one <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      stage_one <= async_in;
      sync_out <= stage_one;
    end
  end

endmodule // input_sync

`default_nettype wire

// *** rtl/watchdog_window.v ***
// Windowed watchdog with fault pulse timer
`timescale 1ns/1ps
`default_nettype none

module watchdog_window #(
  parameter CW = 16
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Control
  input wire tick,
  input wire arm,
  input wire kick_fall,
  input wire [CW-1:0] fast_count,
  input wire [CW-1:0] slow_count,
  // Fault output, active low
  output reg fault_n
);

  reg [CW-1:0] since_kick;
  reg [CW-1:0] pulse_left;
  wire [CW-1:0] pulse_len;

  // Pulse lasts one eighth of the slow window, at least one tick
  assign pulse_len = (slow_count[CW-1:3] == {(CW-3){1'b0}}) ?
                     {{(CW-1){1'b0}}, 1'b1} : {3'h0, slow_count[CW-1:3]};

  // Window counter and fault pulse
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      since_kick <= {CW{1'b0}};
      pulse_left <= {CW{1'b0}};
      fault_n <= 1'b1;
    end else if (!arm) begin
      // Disarm ends a pulse at once (reset low or disable)
      since_kick <= {CW{1'b0}};
      pulse_left <= {CW{1'b0}};
      fault_n <= 1'b1;
    end else if (kick_fall && since_kick < fast_count) begin
      since_kick <= {CW{1'b0}};
      pulse_left <= pulse_len;
      fault_n <= 1'b0;
    end else if (kick_fall) begin
      since_kick <= {CW{1'b0}};
    end else if (tick) begin
      if (since_kick + 1'b1 >= slow_count) begin
        since_kick <= {CW{1'b0}};
        pulse_left <= pulse_len;
        fault_n <= 1'b0;
      end else begin
        since_kick <= since_kick + 1'b1;
      end
      if (pulse_left != {CW{1'b0}} && since_kick + 1'b1 < slow_count) begin
        pulse_left <= pulse_left - 1'b1;
        if (pulse_left == {{(CW-1){1'b0}}, 1'b1})
          fault_n <= 1'b1;
      end
    end
  end

endmodule // watchdog_window

`default_nettype wire

// *** rtl/reset_supervisor.v ***
// Dual-channel sequencing, reset timing and watchdog supervisor with APB
//
// Contract
// - Decode three-state strap into sequencing mode
// - High/low modes: channel two waits for fb1
// - High/open modes: independent reset per channel
// - High/low modes: watchdog waits for both resets
// - Low mode: both resets wait both fb, timer one
// - Open mode: both start, watchdog after reset one
// - Reset held for full delay after fb good
// - Kick too early flags watchdog fault
// - No kick within slow window flags fault
// - Fault pulse low for slow window over eight
// - Disable input high stops the watchdog
// - Startup pulls soft-start low, switching off
// - Soft-start below threshold releases, enables switching
// - Overcurrent inhibits that channel's switching
// - Shutdown input low halts everything
// - Under-voltage asserts that channel's reset
// - Fault pulse ends on timeout or reset low
`timescale 1ns/1ps
`default_nettype none
`include "supervisor_defines.vh"

module reset_supervisor #(
  parameter CW = 16
) (
  // APB clock, reset and slave port
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Strap comparators: high above high level, low below low level
  input wire strap_high_in,
  input wire strap_low_in,
  // Per-channel comparators
  input wire feedback_channel_one,
  input wire feedback_channel_two,
  input wire undervoltage_one,
  input wire undervoltage_two,
  input wire soft_start_low_one,
  input wire soft_start_low_two,
  input wire catch_diode_overcurrent_one,
  input wire catch_diode_overcurrent_two,
  // Shutdown comparator, low means shut down
  input wire shutdown_lockout_in,
  // Watchdog pins
  input wire watchdog_disable_in,
  input wire watchdog_kick_in,
  // Regulator controls
  output reg switch_enable_one,
  output reg switch_enable_two,
  output reg soft_start_pulldown_one,
  output reg soft_start_pulldown_two,
  // Supervisor outputs, active low
  output reg reset_out_one_n,
  output reg reset_out_two_n,
  output wire watchdog_fault_out_n
);

  // Channel soft-start states
  localparam CH_OFF = 2'h0;
  localparam CH_DISCHARGE = 2'h1;
  localparam CH_RUN = 2'h2;

  // Synchronised inputs
  wire [12:0] raw_in;
  wire [12:0] sync_in;
  wire s_strap_high;
  wire s_strap_low;
  wire s_fb_one;
  wire s_fb_two;
  wire s_uv_one;
  wire s_uv_two;
  wire s_ss_low_one;
  wire s_ss_low_two;
  wire s_oc_one;
  wire s_oc_two;
  wire s_enable;
  wire s_wd_disable;
  wire s_kick;

  // Programmed periods
  reg [CW-1:0] tick_div;
  reg [CW-1:0] reset_delay_one;
  reg [CW-1:0] reset_delay_two;
  reg [CW-1:0] wd_fast;
  reg [CW-1:0] wd_slow;

  // Internal state
  reg [CW-1:0] tick_count;
  reg tick;
  reg [1:0] mode;
  reg [1:0] strap_settle;
  reg mode_valid;
  reg [1:0] ch_one_state;
  reg [1:0] ch_two_state;
  reg [CW-1:0] delay_one_count;
  reg [CW-1:0] delay_two_count;
  reg kick_prev;
  reg wd_arm;
  wire kick_fall;
  wire shutdown;
  wire good_one;
  wire good_two;
  wire both_good;
  wire start_two;
  wire apb_setup;
  wire apb_write;
  wire [31:0] status_word;
  reg [31:0] next_rdata;
  reg next_err;

  // Reset delay counter step: clear when bad, count ticks up to delay
  function [CW-1:0] delay_step;
    input [CW-1:0] count;
    input [CW-1:0] limit;
    input good;
    input t;
    begin
      if (!good)
        delay_step = {CW{1'b0}};
      else if (t && count < limit)
        delay_step = count + 1'b1;
      else
        delay_step = count;
    end
  endfunction

  // Soft-start state step for one channel
  function [1:0] channel_step;
    input [1:0] state;
    input halt;
    input start;
    input ss_low;
    begin
      if (halt)
        channel_step = CH_OFF;
      else
        case (state)
          CH_OFF: channel_step = start ? CH_DISCHARGE : CH_OFF;
          CH_DISCHARGE: channel_step = ss_low ? CH_RUN : CH_DISCHARGE;
          CH_RUN: channel_step = CH_RUN;
          default: channel_step = CH_OFF;
        endcase
    end
  endfunction

  // Every asynchronous level passes two flops first
  assign raw_in = {watchdog_kick_in, watchdog_disable_in, shutdown_lockout_in,
                   catch_diode_overcurrent_two, catch_diode_overcurrent_one,
                   soft_start_low_two, soft_start_low_one,
                   undervoltage_two, undervoltage_one,
                   feedback_channel_two, feedback_channel_one,
                   strap_low_in, strap_high_in};

  input_sync #(
    .WIDTH(13)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(raw_in),
    .sync_out(sync_in)
  );

  assign s_strap_high = sync_in[0];
  assign s_strap_low = sync_in[1];
  assign s_fb_one = sync_in[2];
  assign s_fb_two = sync_in[3];
  assign s_uv_one = sync_in[4];
  assign s_uv_two = sync_in[5];
  assign s_ss_low_one = sync_in[6];
  assign s_ss_low_two = sync_in[7];
  assign s_oc_one = sync_in[8];
  assign s_oc_two = sync_in[9];
  assign s_enable = sync_in[10];
  assign s_wd_disable = sync_in[11];
  assign s_kick = sync_in[12];

  // Shutdown also covers the time before the strap is caught
  assign shutdown = !s_enable || !mode_valid;

  // Tick divider: one-cycle enable that paces all timers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_count <= {CW{1'b0}};
      tick <= 1'b0;
    end else if (tick_count + 1'b1 >= tick_div) begin
      tick_count <= {CW{1'b0}};
      tick <= 1'b1;
    end else begin
      tick_count <= tick_count + 1'b1;
      tick <= 1'b0;
    end
  end

  // Strap caught once after release, when the synchroniser has settled
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_settle <= 2'h0;
      mode_valid <= 1'b0;
      mode <= `MODE_OPEN;
    end else if (!mode_valid) begin
      if (strap_settle == 2'h3) begin
        mode_valid <= 1'b1;
        if (s_strap_high)
          mode <= `MODE_TIED_HIGH;
        else if (s_strap_low)
          mode <= `MODE_TIED_LOW;
        else
          mode <= `MODE_OPEN;
      end else begin
        strap_settle <= strap_settle + 2'h1;
      end
    end
  end

  // Feedback good means above threshold and not under-voltage
  assign good_one = s_fb_one && !s_uv_one;
  assign good_two = s_fb_two && !s_uv_two;
  assign both_good = good_one && good_two;

  // Channel two start gate
  assign start_two = (mode == `MODE_OPEN) ? 1'b1 : s_fb_one;

  // Soft-start sequencing; pull-down holds until node is discharged
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ch_one_state <= CH_OFF;
      ch_two_state <= CH_OFF;
    end else begin
      ch_one_state <= channel_step(ch_one_state, shutdown, 1'b1,
                                   s_ss_low_one);
      ch_two_state <= channel_step(ch_two_state, shutdown, start_two,
                                   s_ss_low_two);
    end
  end

  // Regulator controls; overcurrent only pauses switching
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      switch_enable_one <= 1'b0;
      switch_enable_two <= 1'b0;
      soft_start_pulldown_one <= 1'b0;
      soft_start_pulldown_two <= 1'b0;
    end else begin
      switch_enable_one <= (ch_one_state == CH_RUN) && !s_oc_one;
      switch_enable_two <= (ch_two_state == CH_RUN) && !s_oc_two;
      soft_start_pulldown_one <= (ch_one_state == CH_DISCHARGE);
      soft_start_pulldown_two <= (ch_two_state == CH_DISCHARGE);
    end
  end

  // Reset delay timers; low mode runs timer one on the joint condition
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      delay_one_count <= {CW{1'b0}};
      delay_two_count <= {CW{1'b0}};
    end else if (shutdown) begin
      delay_one_count <= {CW{1'b0}};
      delay_two_count <= {CW{1'b0}};
    end else if (mode == `MODE_TIED_LOW) begin
      delay_one_count <= delay_step(delay_one_count, reset_delay_one,
                                    both_good, tick);
      delay_two_count <= {CW{1'b0}};
    end else begin
      delay_one_count <= delay_step(delay_one_count, reset_delay_one,
                                    good_one, tick);
      delay_two_count <= delay_step(delay_two_count, reset_delay_two,
                                    good_two, tick);
    end
  end

  // Reset outputs released only after the full delay
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reset_out_one_n <= 1'b0;
      reset_out_two_n <= 1'b0;
    end else if (shutdown) begin
      reset_out_one_n <= 1'b0;
      reset_out_two_n <= 1'b0;
    end else if (mode == `MODE_TIED_LOW) begin
      reset_out_one_n <= both_good &&
                         delay_one_count >= reset_delay_one;
      reset_out_two_n <= both_good &&
                         delay_one_count >= reset_delay_one;
    end else begin
      reset_out_one_n <= good_one &&
                         delay_one_count >= reset_delay_one;
      reset_out_two_n <= good_two &&
                         delay_two_count >= reset_delay_two;
    end
  end

  // Watchdog arming per mode; disable pin wins
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_arm <= 1'b0;
    end else if (shutdown || s_wd_disable) begin
      wd_arm <= 1'b0;
    end else if (mode == `MODE_OPEN) begin
      wd_arm <= reset_out_one_n;
    end else begin
      wd_arm <= reset_out_one_n && reset_out_two_n;
    end
  end

  // Kick edge taken from the settled level only; the synchroniser leaves
  // reset low, so a high history here would fake a fall
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      kick_prev <= 1'b0;
    else
      kick_prev <= s_kick;
  end
  assign kick_fall = kick_prev && !s_kick;

  // Arm drops with reset one low, or with either reset low outside open mode, which ends a fault pulse early
  watchdog_window #(
    .CW(CW)
  ) u_watchdog (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick),
    .arm(wd_arm),
    .kick_fall(kick_fall),
    .fast_count(wd_fast),
    .slow_count(wd_slow),
    .fault_n(watchdog_fault_out_n)
  );

  // APB decode
  assign apb_setup = psel && !penable;
  assign apb_write = psel && penable && pready && pwrite;

  assign status_word = {21'h000000, shutdown, wd_arm,
                        soft_start_pulldown_two, soft_start_pulldown_one,
                        switch_enable_two, switch_enable_one,
                        watchdog_fault_out_n, reset_out_two_n,
                        reset_out_one_n, mode};

  // Read mux and unmapped-address check
  always @* begin
    next_rdata = 32'h00000000;
    next_err = 1'b0;
    case (paddr)
      `REG_TICK_DIV: next_rdata = {16'h0000, tick_div};
      `REG_RESET_DELAY_ONE: next_rdata = {16'h0000, reset_delay_one};
      `REG_RESET_DELAY_TWO: next_rdata = {16'h0000, reset_delay_two};
      `REG_WD_FAST: next_rdata = {16'h0000, wd_fast};
      `REG_WD_SLOW: next_rdata = {16'h0000, wd_slow};
      `REG_STATUS: next_rdata = status_word;
      default: next_err = 1'b1;
    endcase
  end

  // Answer registered in setup, so access completes with no wait
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else if (apb_setup) begin
      pready <= 1'b1;
      pslverr <= next_err;
      prdata <= pwrite ? 32'h00000000 : next_rdata;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
  end

  // Programmable periods; a zero divider would stall nothing, it ticks
  // every cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_div <= `TICK_DIV_RESET;
      reset_delay_one <= `RESET_DELAY_ONE_RESET;
      reset_delay_two <= `RESET_DELAY_TWO_RESET;
      wd_fast <= `WD_FAST_RESET;
      wd_slow <= `WD_SLOW_RESET;
    end else if (apb_write && !pslverr) begin
      case (paddr)
        `REG_TICK_DIV: tick_div <= pwdata[CW-1:0];
        `REG_RESET_DELAY_ONE: reset_delay_one <= pwdata[CW-1:0];
        `REG_RESET_DELAY_TWO: reset_delay_two <= pwdata[CW-1:0];
        `REG_WD_FAST: wd_fast <= pwdata[CW-1:0];
        `REG_WD_SLOW: wd_slow <= pwdata[CW-1:0];
        default: tick_div <= tick_div;
      endcase
    end
  end

endmodule // reset_supervisor

`default_nettype wire

// *** bench/supervisor_props.sv ***
// Pin-level checker for the dual reset and watchdog supervisor
`timescale 1ns/1ps
`default_nettype none
module supervisor_props #(
  parameter CW = 16
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bus handshake
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  // Pin inputs
  input wire logic strap_high_in,
  input wire logic strap_low_in,
  input wire logic feedback_channel_one,
  input wire logic undervoltage_one,
  input wire logic catch_diode_overcurrent_one,
  input wire logic shutdown_lockout_in,
  input wire logic watchdog_disable_in,
  // Pin outputs
  input wire logic switch_enable_one,
  input wire logic switch_enable_two,
  input wire logic soft_start_pulldown_one,
  input wire logic soft_start_pulldown_two,
  input wire logic reset_out_one_n,
  input wire logic reset_out_two_n,
  input wire logic watchdog_fault_out_n
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [15:0] good_cnt;
  // Cycles channel one has looked good; saturates so it never wraps
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) good_cnt <= 16'h0;
    else if (!feedback_channel_one || undervoltage_one) good_cnt <= 16'h0;
    else if (good_cnt != 16'hffff) good_cnt <= good_cnt + 16'h1;
  end
  sequence fault_start;
    $fell(watchdog_fault_out_n);
  endsequence
  apb_ready_a: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  shut_halt_a: assert property (!shutdown_lockout_in [*6] |->
    !switch_enable_one && !switch_enable_two && !reset_out_one_n)
    else $error("activity during shutdown");
  overcur_a: assert property (catch_diode_overcurrent_one [*6] |->
    !switch_enable_one) else $error("switching during overcurrent");
  ss_pull_a: assert property (soft_start_pulldown_one |->
    !switch_enable_one) else $error("switching while discharging");
  uv_reset_a: assert property (undervoltage_one [*6] |->
    !reset_out_one_n) else $error("reset not asserted on undervoltage");
  delay_full_a: assert property ($rose(reset_out_one_n) |->
    good_cnt >= 16'd20) else $error("reset released early");
  arm_one_a: assert property (fault_start |-> reset_out_one_n)
    else $error("fault while reset one low");
  arm_both_a: assert property (fault_start ##0
    (strap_high_in || strap_low_in) |-> reset_out_two_n)
    else $error("fault before both resets released");
  pulse_end_a: assert property (!reset_out_one_n [*3] |->
    watchdog_fault_out_n) else $error("fault held during reset");
  wd_off_a: assert property (watchdog_disable_in [*6] |->
    watchdog_fault_out_n) else $error("fault while disabled");
  joint_rst_a: assert property ($rose(reset_out_one_n) &&
    strap_low_in && !strap_high_in |-> reset_out_two_n)
    else $error("resets released apart");
  ch2_wait_a: assert property ($rose(soft_start_pulldown_two) &&
    (strap_high_in || strap_low_in) |-> $past(feedback_channel_one, 2))
    else $error("channel two started early");
endmodule // supervisor_props
bind reset_supervisor supervisor_props #(.CW(CW)) supervisor_props_i (.*);
`default_nettype wire

// *** bench/cpu_model.sv ***
// Processor model that kicks the watchdog while out of reset
`timescale 1ns/1ps
`default_nettype none
module cpu_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Kick spacing in cycles, zero stops kicking
  input wire logic [7:0] kick_period,
  // Resets from the supervisor
  input wire logic reset_out_one_n,
  input wire logic reset_out_two_n,
  // Kick pin, idles high
  output logic watchdog_kick_in
);
  logic [7:0] cnt;
  // Low phase is 30 cycles so every kick meets the 300 ns minimum width
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 8'h00;
      watchdog_kick_in <= 1'b1;
    end else if (!reset_out_one_n || !reset_out_two_n ||
                 kick_period == 8'h00) begin
      cnt <= 8'h00;
      watchdog_kick_in <= 1'b1;
    end else begin
      cnt <= (cnt == kick_period - 8'h01) ? 8'h00 : cnt + 8'h01;
      if (cnt == kick_period - 8'h01) watchdog_kick_in <= 1'b0;
      else if (cnt == 8'h1d) watchdog_kick_in <= 1'b1;
    end
  end
endmodule // cpu_model
`default_nettype wire

// *** bench/dual_reset_watchdog_supervisor_tb_top.sv ***
// Self-checking bench for the dual reset and watchdog supervisor
`timescale 1ns/1ps
`default_nettype none
`include "supervisor_defines.vh"
module dual_reset_watchdog_supervisor_tb_top;
  localparam int TD = 2, DLY = 10, FAST = 40, SLOW = 96;
  logic pclk = 1'b0, presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00, kick_period = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, e, watchdog_kick_in;
  logic strap_high_in = 1'b1, strap_low_in = 1'b0;
  logic feedback_channel_one = 1'b0, feedback_channel_two = 1'b0;
  logic undervoltage_one = 1'b0, undervoltage_two = 1'b0;
  logic soft_start_low_one = 1'b0, soft_start_low_two = 1'b0;
  logic catch_diode_overcurrent_one = 1'b0;
  logic catch_diode_overcurrent_two = 1'b0;
  logic shutdown_lockout_in = 1'b0, watchdog_disable_in = 1'b0;
  logic switch_enable_one, switch_enable_two;
  logic soft_start_pulldown_one, soft_start_pulldown_two;
  logic reset_out_one_n, reset_out_two_n, watchdog_fault_out_n;
  int n_mismatch = 0, n_compared = 0, n, f, n_fall = 0;
  typedef struct {
    logic [7:0] a; logic we; logic [31:0] d; logic [31:0] q; logic e;
  } row_t;
  // Reset values first, then the short test periods, then a bad address
  row_t rows [11] = '{
    '{`REG_TICK_DIV, 1'b0, 32'h0, `TICK_DIV_RESET, 1'b0},
    '{`REG_RESET_DELAY_ONE, 1'b0, 32'h0, `RESET_DELAY_ONE_RESET, 1'b0},
    '{`REG_RESET_DELAY_TWO, 1'b0, 32'h0, `RESET_DELAY_TWO_RESET, 1'b0},
    '{`REG_WD_FAST, 1'b0, 32'h0, `WD_FAST_RESET, 1'b0},
    '{`REG_WD_SLOW, 1'b0, 32'h0, `WD_SLOW_RESET, 1'b0},
    '{`REG_TICK_DIV, 1'b1, TD, TD, 1'b0},
    '{`REG_RESET_DELAY_ONE, 1'b1, 32'hffff0000 | DLY, DLY, 1'b0},
    '{`REG_RESET_DELAY_TWO, 1'b1, DLY, DLY, 1'b0},
    '{`REG_WD_FAST, 1'b1, FAST, FAST, 1'b0},
    '{`REG_WD_SLOW, 1'b1, SLOW, SLOW, 1'b0},
    '{8'h18, 1'b1, 32'h5, 32'h0, 1'b1}};

  reset_supervisor reset_supervisor_i (.*);
  cpu_model cpu_model_i (.*);

  // Free-running 100 MHz clock
  always #5 pclk = ~pclk;
  // Fault pulses seen on the pin
  always @(negedge watchdog_fault_out_n) n_fall++;

  task automatic give_verdict;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk_val(input string s, input logic [31:0] x, y);
    n_compared++;
    if (y !== x) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", s, x, y);
    end
  endtask
  task automatic chk_rng(input string s, input int v, lo, hi);
    n_compared++;
    if (v < lo || v > hi) begin
      n_mismatch++;
      $display("mismatch %s expected %0d..%0d seen %0d", s, lo, hi, v);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask
  // One APB transfer; an idle cycle follows so psel never toggles twice
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] rq,
                     output logic re);
    int t;
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    t = 0;
    do begin @(posedge pclk); t++; end while (pready !== 1'b1 && t < 20);
    chk_val("pready", 1, pready);
    rq = prdata;
    re = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask
  function automatic logic pin(input int s);
    case (s)
      0: return reset_out_one_n;
      1: return reset_out_two_n;
      default: return watchdog_fault_out_n;
    endcase
  endfunction
  // Bounded wait for a pin level, giving cycles taken
  task automatic wait_pin(input int s, input logic lvl, output int k);
    k = 0;
    do begin @(posedge pclk); k++; end while (pin(s) !== lvl && k < 400);
  endtask
  task automatic restart(input logic hi, lo);
    presetn <= 1'b0; strap_high_in <= hi; strap_low_in <= lo;
    shutdown_lockout_in <= 1'b0; kick_period <= 8'h00;
    feedback_channel_one <= 1'b0; feedback_channel_two <= 1'b0;
    soft_start_low_one <= 1'b0; soft_start_low_two <= 1'b0;
    undervoltage_one <= 1'b0; watchdog_disable_in <= 1'b0;
    cyc(3);
    presetn <= 1'b1;
    cyc(1);
  endtask
  task automatic prog;
    for (int i = 5; i < 10; i++) apb(1'b1, rows[i].a, rows[i].d, q, e);
  endtask
  // Status is read-only: the write must leave mode and shutdown intact
  task automatic stat(input logic [31:0] x);
    apb(1'b1, `REG_STATUS, 32'hffffffff, q, e);
    apb(1'b0, `REG_STATUS, 32'h0, q, e);
    chk_val("status", x, q & 32'h403);
  endtask

  initial begin
    restart(1'b1, 1'b0);
    for (int i = 0; i < 11; i++) begin
      if (rows[i].we) apb(1'b1, rows[i].a, rows[i].d, q, e);
      apb(1'b0, rows[i].a, 32'h0, q, e);
      chk_val("prdata", rows[i].q, q);
      chk_val("pslverr", rows[i].e, e);
    end
    stat(32'h400 | `MODE_TIED_HIGH);
    shutdown_lockout_in <= 1'b1;
    cyc(8);
    chk_val("discharge", 2'b10, {soft_start_pulldown_one, switch_enable_one});
    chk_val("pulldown2", 0, soft_start_pulldown_two);
    soft_start_low_one <= 1'b1;
    cyc(8);
    chk_val("run1", 2'b01, {soft_start_pulldown_one, switch_enable_one});
    catch_diode_overcurrent_one <= 1'b1;
    cyc(8);
    chk_val("switch1", 0, switch_enable_one);
    catch_diode_overcurrent_one <= 1'b0;
    cyc(8);
    chk_val("switch1", 1, switch_enable_one);
    feedback_channel_one <= 1'b1;
    wait_pin(0, 1'b1, n);
    chk_rng("delay1", n, 20, 27);
    chk_val("pulldown2", 1, soft_start_pulldown_two);
    cyc(200);
    chk_val("reset2", 0, reset_out_two_n);
    chk_val("fault", 1, watchdog_fault_out_n);
    soft_start_low_two <= 1'b1;
    feedback_channel_two <= 1'b1;
    wait_pin(1, 1'b1, n);
    chk_rng("delay2", n, 20, 27);
    chk_val("switch2", 1, switch_enable_two);
    wait_pin(2, 1'b0, n);
    chk_rng("slow timeout", n, 189, 198);
    wait_pin(2, 1'b1, n);
    chk_rng("fault pulse", n, 22, 26);
    kick_period <= 8'd120;
    f = n_fall;
    cyc(600);
    chk_val("falls", f, n_fall);
    kick_period <= 8'h00;
    cyc(1);
    kick_period <= 8'd40;
    wait_pin(2, 1'b0, n);
    chk_rng("early kick", n, 40, 100);
    undervoltage_one <= 1'b1;
    kick_period <= 8'h00;
    wait_pin(2, 1'b1, n);
    chk_rng("fault end", n, 1, 10);
    chk_val("reset1", 0, reset_out_one_n);
    undervoltage_one <= 1'b0;
    watchdog_disable_in <= 1'b1;
    wait_pin(0, 1'b1, n);
    f = n_fall;
    catch_diode_overcurrent_two <= 1'b1;
    undervoltage_two <= 1'b1;
    cyc(8);
    chk_val("ch2", 0, {switch_enable_two, reset_out_two_n});
    catch_diode_overcurrent_two <= 1'b0;
    undervoltage_two <= 1'b0;
    cyc(392);
    chk_val("falls", f, n_fall);
    watchdog_disable_in <= 1'b0;
    wait_pin(2, 1'b0, n);
    chk_rng("rearm", n, 189, 202);
    shutdown_lockout_in <= 1'b0;
    cyc(8);
    chk_val("halted", 0, {switch_enable_one, switch_enable_two,
      reset_out_one_n, reset_out_two_n});
    restart(1'b0, 1'b1);
    prog();
    shutdown_lockout_in <= 1'b1;
    soft_start_low_one <= 1'b1;
    soft_start_low_two <= 1'b1;
    feedback_channel_one <= 1'b1;
    cyc(100);
    chk_val("resets", 0, {reset_out_one_n, reset_out_two_n});
    stat(`MODE_TIED_LOW);
    feedback_channel_two <= 1'b1;
    wait_pin(0, 1'b1, n);
    chk_rng("joint", n, 20, 27);
    chk_val("resets", 2'b11, {reset_out_one_n, reset_out_two_n});
    restart(1'b0, 1'b0);
    prog();
    shutdown_lockout_in <= 1'b1;
    cyc(8);
    chk_val("pulldowns", 2'b11, {soft_start_pulldown_one,
      soft_start_pulldown_two});
    stat(`MODE_OPEN);
    feedback_channel_one <= 1'b1;
    wait_pin(0, 1'b1, n);
    wait_pin(2, 1'b0, n);
    chk_rng("open arm", n, 189, 198);
    chk_val("reset2", 0, reset_out_two_n);
    give_verdict();
  end
  // Hang guard, well beyond the expected run length
  initial begin
    #400000;
    n_mismatch++;
    give_verdict();
  end
endmodule // dual_reset_watchdog_supervisor_tb_top
`default_nettype wire
